/* rtl/port_expander_pkg.sv */
// Summary of operation
// RQ1: input pins switch both output drivers off, leaving a weak pull-up.
// RQ2: output pins drive high or low following their output latch bit.
// RQ3: sda falling while scl high is taken as a start condition.
// RQ4: master sends the address byte msb first, direction bit last.
// RQ5: matching address is acknowledged by holding sda low on the ninth pulse.
// RQ6: address select pins stay constant between start and stop.
// RQ7: sda changes only while scl low; changes while high are start or stop.
// RQ8: sda rising while scl high is a stop; bus logic returns to idle.
// RQ9: each byte is eight bits plus one acknowledge; transmitter releases sda.
// RQ10: as receiver, every received byte is acknowledged with sda low.
// RQ11: master nack on last read byte; device releases sda for the stop.
// RQ12: slave address is 0100 followed by the three address select pins.
// RQ13: last address bit one means read, zero means write.
// RQ14: first write byte after address is the command; low bits pick register.
// RQ15: selected register stays the read target until a new command byte.
// RQ16: register 0 reads present pin levels; writes to it are ignored.
// RQ17: invert bits of one invert the reported input level; reset to zero.
// RQ18: output latch reads return stored values; reset to all ones.
// RQ19: direction bit one means input, zero output; reset to all ones.
// RQ20: reset puts pins in input mode, restores registers and bus logic.
// RQ21: master starts a transfer only while the bus is idle.
// RQ22: any number of data bytes is accepted between start and stop.
// RQ23: read is command write, repeated start, address with read bit set.
// RQ24: input levels are captured at the rising edge of each ack clock; the first read byte uses the level at the address ack clock's fall.
// RQ25: scl and sda are synchronised and their edges found from samples.
package port_expander_pkg;
  localparam logic [1:0] REG_INPUT_LEVELS = 2'h0;
  localparam logic [1:0] REG_OUTPUT_LATCH = 2'h1;
  localparam logic [1:0] REG_INVERT_MASK = 2'h2;
  localparam logic [1:0] REG_DIRECTION_MASK = 2'h3;
  localparam logic [7:0] RST_OUTPUT_LATCH = 8'hff;
  localparam logic [7:0] RST_INVERT_MASK = 8'h00;
  localparam logic [7:0] RST_DIRECTION_MASK = 8'hff;
  localparam logic [3:0] ADDR_FIXED_BITS = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_ADDR_ACK = 6'b00_0100,
    ST_RX = 6'b00_1000,
    ST_RX_ACK = 6'b01_0000,
    ST_TX = 6'b10_0000
  } bus_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic is_cmd;
  } rx_word_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] pin_meta;
    logic [7:0] pin_level;
    logic [2:0] sel_meta;
    logic [2:0] sel_level;
  } sync_t;
endpackage

/* rtl/port_expander.sv */
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------------
// write-data fifo
// --------------------------------------------------------------------------
module rx_word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t st_ff, nxt_st;
  logic push, pop;

  // --------------------------------------------------------------------------
  // pointers and fill count
  // --------------------------------------------------------------------------
  // a full queue refuses the push; the writer must hold or drop the word
  always_comb begin
    in_ready = (st_ff.cnt != (AW+1)'(DEPTH));
    out_valid = (st_ff.cnt != '0);
    out_data = st_ff.mem[st_ff.rd];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // storage register
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // rx_word_fifo

// --------------------------------------------------------------------------
// i2c port expander
// --------------------------------------------------------------------------
module port_expander
  import port_expander_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic [7:0] port_pin_in,
  output logic [7:0] port_pin_out,
  output logic [7:0] port_pin_oe,
  output logic [7:0] high_side_driver,
  output logic [7:0] low_side_driver
);
  // --------------------------------------------------------------------------
  // held state
  // --------------------------------------------------------------------------
  typedef struct packed {
    sync_t sy;
    bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw_read;
    logic first_byte;
    logic [6:0] addr_lat;
    logic sda_low;
    logic [1:0] reg_sel;
    logic [7:0] input_cap;
    logic [7:0] pin_output_latch;
    logic [7:0] input_invert_mask;
    logic [7:0] pin_direction_mask;
  } core_t;

  core_t st_ff, nxt_st;
  logic scl_rise, scl_fall, start_det, stop_det, scl_h, sda_h;
  logic push_valid, push_ready, pop_valid;
  rx_word_t push_word, pop_word;
  logic [6:0] own_addr;
  logic [7:0] in_view;

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------
  // during a read the ack slot belongs to the master
  function automatic logic read_ack_slot(input core_t s);
    read_ack_slot = (s.state == ST_RX_ACK) && s.rw_read;
  endfunction

  function automatic logic [7:0] read_reg(input logic [1:0] sel, input core_t s,
                                          input logic [7:0] levels);
    case (sel)
      REG_INPUT_LEVELS: read_reg = levels;
      REG_OUTPUT_LATCH: read_reg = s.pin_output_latch; // RQ18
      REG_INVERT_MASK: read_reg = s.input_invert_mask;
      default: read_reg = s.pin_direction_mask;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // write queue
  // --------------------------------------------------------------------------
  // write bytes queue up so register updates never race bit timing
  rx_word_fifo #(.WIDTH($bits(rx_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(pop_valid),
    .out_ready(1'b1),
    .out_data(pop_word)
  );

  // --------------------------------------------------------------------------
  // synchronisers and bus engine
  // --------------------------------------------------------------------------
  // edges are seen about three clocks late, so each scl phase
  // must last at least four clocks for a bit to be taken cleanly
  always_comb begin
    scl_h = st_ff.sy.scl_sync[1]; // RQ25
    sda_h = st_ff.sy.sda_sync[1];
    scl_rise = scl_h && !st_ff.sy.scl_prev;
    scl_fall = !scl_h && st_ff.sy.scl_prev;
    start_det = scl_h && st_ff.sy.scl_prev && !sda_h && st_ff.sy.sda_prev; // RQ3 RQ7
    stop_det = scl_h && st_ff.sy.scl_prev && sda_h && !st_ff.sy.sda_prev; // RQ8 RQ7
    own_addr = {ADDR_FIXED_BITS, st_ff.sy.sel_level}; // RQ12
    in_view = st_ff.sy.pin_level ^ st_ff.input_invert_mask; // RQ17
    push_valid = 1'b0;
    push_word = '0;
    nxt_st = st_ff;
    nxt_st.sy.scl_sync = {st_ff.sy.scl_sync[0], scl_in};
    nxt_st.sy.sda_sync = {st_ff.sy.sda_sync[0], sda_in};
    nxt_st.sy.scl_prev = scl_h;
    nxt_st.sy.sda_prev = sda_h;
    nxt_st.sy.pin_meta = port_pin_in;
    nxt_st.sy.pin_level = st_ff.sy.pin_meta;
    nxt_st.sy.sel_meta = {addr_select_bit2, addr_select_bit1, addr_select_bit0}; // RQ6
    nxt_st.sy.sel_level = st_ff.sy.sel_meta;

    // queued writes; input register is read only
    if (pop_valid) begin
      if (pop_word.is_cmd) begin
        nxt_st.reg_sel = pop_word.data[1:0]; // RQ14 RQ15
      end else begin
        case (st_ff.reg_sel)
          REG_OUTPUT_LATCH: nxt_st.pin_output_latch = pop_word.data;
          REG_INVERT_MASK: nxt_st.input_invert_mask = pop_word.data;
          REG_DIRECTION_MASK: nxt_st.pin_direction_mask = pop_word.data;
          default: nxt_st.reg_sel = st_ff.reg_sel; // RQ16
        endcase
      end
    end

    case (st_ff.state)
      ST_IDLE: begin
        nxt_st.sda_low = 1'b0;
      end
      ST_ADDR: begin
        if (scl_rise) begin
          nxt_st.shift = {st_ff.shift[6:0], sda_h}; // RQ4
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
        end
        if (scl_fall && st_ff.bit_cnt == BITS_PER_BYTE) begin
          if (st_ff.shift[7:1] == st_ff.addr_lat) begin
            nxt_st.state = ST_ADDR_ACK;
            nxt_st.sda_low = 1'b1; // RQ5
            nxt_st.rw_read = st_ff.shift[0]; // RQ13
          end else begin
            nxt_st.state = ST_IDLE;
          end
        end
      end
      ST_ADDR_ACK, ST_RX_ACK: begin
        if (scl_rise) begin
          nxt_st.input_cap = in_view; // RQ24
        end
        if (scl_fall) begin
          nxt_st.bit_cnt = 4'h0;
          if (st_ff.state == ST_RX_ACK && !st_ff.sda_low) begin
            // master nack: let go of sda, wait for stop
            nxt_st.state = ST_IDLE; // RQ11
          end else if (st_ff.rw_read) begin
            nxt_st.state = ST_TX;
            nxt_st.shift = read_reg(st_ff.reg_sel, st_ff,
                                    (st_ff.state == ST_ADDR_ACK) ? in_view : st_ff.input_cap);
            nxt_st.sda_low = !nxt_st.shift[7];
          end else begin
            nxt_st.state = ST_RX;
            nxt_st.sda_low = 1'b0; // RQ9
          end
        end else if (read_ack_slot(st_ff) && scl_rise) begin
          nxt_st.sda_low = !sda_h; // remember master ack
        end
      end
      ST_RX: begin
        if (scl_rise) begin
          nxt_st.shift = {st_ff.shift[6:0], sda_h};
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
        end
        if (scl_fall && st_ff.bit_cnt == BITS_PER_BYTE) begin
          // full fifo: the byte is dropped and the ack withheld
          if (push_ready) begin
            push_valid = 1'b1;
            push_word.data = st_ff.shift;
            push_word.is_cmd = st_ff.first_byte; // RQ14
            nxt_st.first_byte = 1'b0;
            nxt_st.sda_low = 1'b1; // RQ10 RQ22
          end
          nxt_st.state = ST_RX_ACK;
          nxt_st.rw_read = 1'b0;
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          nxt_st.shift = {st_ff.shift[6:0], 1'b1};
          nxt_st.sda_low = !st_ff.shift[6];
          if (st_ff.bit_cnt == BITS_PER_BYTE - 4'h1) begin
            nxt_st.state = ST_RX_ACK;
            nxt_st.sda_low = 1'b0; // RQ9
          end
        end
      end
      default: nxt_st.state = ST_IDLE;
    endcase

    if (start_det) begin
      nxt_st.state = ST_ADDR; // RQ23
      // address pins are frozen for the whole frame
      nxt_st.addr_lat = own_addr; // RQ6 RQ12
      nxt_st.bit_cnt = 4'h0;
      nxt_st.sda_low = 1'b0;
      nxt_st.first_byte = 1'b1;
    end else if (stop_det) begin
      nxt_st.state = ST_IDLE; // RQ8
      nxt_st.sda_low = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // bus and pin drivers
  // --------------------------------------------------------------------------
  // ack during a read: master drives sda, device stays released
  always_comb begin
    sda_out = 1'b0;
    sda_oe = st_ff.sda_low && !read_ack_slot(st_ff);
    port_pin_out = st_ff.pin_output_latch; // RQ2
    port_pin_oe = ~st_ff.pin_direction_mask; // RQ19
  end

  // both drivers of an input pin stay off, so only the weak pull-up remains
  for (genvar p = 0; p < 8; p++) begin : g_pin_drv
    wire logic drive_on = !st_ff.pin_direction_mask[p];
    assign high_side_driver[p] = drive_on && st_ff.pin_output_latch[p]; // RQ1 RQ2
    assign low_side_driver[p] = drive_on && !st_ff.pin_output_latch[p]; // RQ1 RQ2
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0; // RQ20
      // idle bus levels, so no false edge follows reset
      st_ff.sy.scl_sync <= 2'b11;
      st_ff.sy.sda_sync <= 2'b11;
      st_ff.sy.scl_prev <= 1'b1;
      st_ff.sy.sda_prev <= 1'b1;
      st_ff.state <= ST_IDLE;
      st_ff.reg_sel <= REG_INPUT_LEVELS;
      st_ff.sda_low <= 1'b0;
      st_ff.bit_cnt <= 4'h0;
      st_ff.addr_lat <= {ADDR_FIXED_BITS, 3'h0};
      st_ff.pin_output_latch <= RST_OUTPUT_LATCH;
      st_ff.input_invert_mask <= RST_INVERT_MASK;
      st_ff.pin_direction_mask <= RST_DIRECTION_MASK;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // port_expander

`default_nettype wire

/* dv/port_expander_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// --------
// pin and bus checks
// --------
module port_expander_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe,
  input wire logic [7:0] high_side_driver,
  input wire logic [7:0] low_side_driver
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  drv_off_a: assert property (
    ((high_side_driver | low_side_driver) & ~port_pin_oe) == 8'h00)
    else $error("driver on at an input pin");
  drv_high_a: assert property (high_side_driver == (port_pin_oe & port_pin_out))
    else $error("high side driver wrong");
  drv_low_a: assert property (low_side_driver == (port_pin_oe & ~port_pin_out))
    else $error("low side driver wrong");
  reset_dflt_a: assert property ($rose(resetn) |->
    port_pin_oe == 8'h00 && port_pin_out == 8'hff && !sda_oe)
    else $error("not at defaults after reset");
  stop_idle_a: assert property ($rose(sda_in) && scl_in |=> (!sda_oe) [*4])
    else $error("sda driven after stop");
  // late changes after a clock fall are tolerated by the two-cycle look-back
  sda_stable_a: assert property ($changed(sda_oe) |-> !(scl_in && $past(scl_in, 2)))
    else $error("sda changed while scl high");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("sda low not held for a bit");
  sda_low_a: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
endmodule  // port_expander_chk
`default_nettype wire

/* dv/i2c_mst.sv */
`timescale 1ns/1ps
`default_nettype none
// --------
// bus master, 200 ns clock
// --------
module i2c_mst (
  input wire logic sda_w,
  output logic scl_o,
  output logic sda_o
);
  // scl parks high between frames; sda_o high means released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start;
    #100 sda_o = 1'b1;  // late, a slave ack may still hold the line
    #50 scl_o = 1'b1;
    #100 sda_o = 1'b0;
    #100 scl_o = 1'b0;
  endtask
  task automatic stop;
    #50 sda_o = 1'b0;
    #50 scl_o = 1'b1;
    #100 sda_o = 1'b1;
    #100;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #50 sda_o = b;
    #50 scl_o = 1'b1;
    #50 r = sda_w;
    #50 scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ma, ack);
  endtask
endmodule  // i2c_mst
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// --------
// bench top
// --------
module testbench;
  import port_expander_pkg::*;
  logic sys_clk, resetn, sda_out, sda_oe, scl_m, sda_m, a;
  logic [2:0] asel;
  logic [7:0] ext, q, port_pin_out, port_pin_oe, pin_lvl;
  logic [7:0] m [4];
  logic [31:0] seed;
  int miscompares, checks;
  wire logic sda_w = sda_m & ~(sda_oe & ~sda_out);
  // output pins read back their own driven level
  assign pin_lvl = (port_pin_oe & port_pin_out) | (~port_pin_oe & ext);
  port_expander u_port_expander (.sys_clk, .resetn, .scl_in(scl_m), .sda_in(sda_w), .sda_out,
    .sda_oe, .addr_select_bit0(asel[0]), .addr_select_bit1(asel[1]),
    .addr_select_bit2(asel[2]), .port_pin_in(pin_lvl), .port_pin_out, .port_pin_oe,
    .high_side_driver(), .low_side_driver());
  i2c_mst u_i2c_mst (.sda_w, .scl_o(scl_m), .sda_o(sda_m));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] expv(input logic [1:0] r);
    if (r != REG_INPUT_LEVELS) return m[r];
    return ((~m[3] & m[1]) | (m[3] & ext)) ^ m[2];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic sb(input logic [7:0] d, input logic ea);
    u_i2c_mst.xfer(d, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, ea});
  endtask
  task automatic cmd(input logic [1:0] r);
    u_i2c_mst.start();
    sb({ADDR_FIXED_BITS, asel, 1'b0}, 1'b0);
    sb({6'h00, r}, 1'b0);
  endtask
  task automatic wr(input logic [1:0] r, input logic [7:0] d);
    cmd(r);
    sb(d, 1'b0);
    sb(d, 1'b0);
    u_i2c_mst.stop();
    if (r != REG_INPUT_LEVELS) m[r] = d;
  endtask
  // c low reuses the command left from earlier
  task automatic rd(input logic [1:0] r, input logic c);
    if (c) cmd(r);
    u_i2c_mst.start();
    sb({ADDR_FIXED_BITS, asel, 1'b1}, 1'b0);
    for (int k = 0; k < 2; k++) begin
      u_i2c_mst.xfer(8'hff, k[0], q, a);
      chk(q, expv(r));
    end
    u_i2c_mst.stop();
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    #2 resetn = 1'b0;
    m = '{8'h00, RST_OUTPUT_LATCH, RST_INVERT_MASK, RST_DIRECTION_MASK};
    repeat (10) @(posedge sys_clk);
    #2 resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2;
    for (int i = 0; i < 4; i++) rd(i[1:0], 1'b1);
  endtask
  initial begin
    seed = 32'h0000_f2c2;
    asel = 3'h0;
    ext = 8'h00;
    resetn = 1'b0;
    miscompares = 0;
    checks = 0;
    do_reset();
    wr(REG_DIRECTION_MASK, 8'h00);
    wr(REG_INVERT_MASK, 8'hff);
    wr(REG_INPUT_LEVELS, 8'h5a);
    rd(REG_INPUT_LEVELS, 1'b1);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      @(posedge sys_clk);
      #2 asel = seed[10:8];
      ext = seed[7:0];
      wr(seed[12:11], seed[23:16]);
      chk(port_pin_oe, ~m[3]);
      chk(port_pin_out, m[1]);
      rd(seed[12:11], 1'b0);
      rd(seed[14:13], 1'b1);
      u_i2c_mst.start();
      sb({ADDR_FIXED_BITS, asel ^ (seed[26:24] | 3'h1), 1'b0}, 1'b1);
      u_i2c_mst.stop();
    end
    do_reset();
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
endmodule  // testbench
bind port_expander port_expander_chk u_port_expander_chk (.sys_clk, .resetn, .scl_in,
  .sda_in, .sda_out, .sda_oe, .port_pin_out, .port_pin_oe, .high_side_driver,
  .low_side_driver);
`default_nettype wire
